/* File: logic/cssq_pkg.sv */
// package: constants and types for the cascade supply sequencer
package cssq_pkg;
  // clock rate and derived cycle counts
  localparam int CLK_HZ = 40_000_000;
  localparam int EMPTY_SLOT_US = 25; // empty position release time
  localparam int EMPTY_SLOT_CYC = (EMPTY_SLOT_US * (CLK_HZ / 1_000_000));
  localparam int MIN_HIGH_US = 100; // least slot timer high time
  localparam int MIN_HIGH_CYC = (MIN_HIGH_US * (CLK_HZ / 1_000_000));
  localparam int SLOT_TIMER_DEF = 4000; // default slot timer period in cycles
  localparam int NUM_POS = 8; // time positions
  localparam int NUM_SUP = 4; // supplies per device
  localparam logic [3:0] FIRST_POS = 4'h1;
  localparam logic [3:0] LAST_POS = 4'h8;
  localparam logic [3:0] POS_RESET = 4'h0;
  localparam logic [2:0] ROLE_SETTLE_CYC = 3'h6; // cycles before roles and link are trusted
  // three-state role pin levels
  typedef enum logic [1:0] {CSSQ_LV_GND, CSSQ_LV_OPEN, CSSQ_LV_VCC} cssq_level_t;
  // decoded role
  typedef struct packed {
    logic master;
    logic first;
    logic reset_faults;
    logic no_shutdown;
  } cssq_role_t;
  // role decode of the nine pin combinations
  function automatic cssq_role_t cssq_decode(input cssq_level_t a, input cssq_level_t b);
    cssq_role_t r;
    r = '{master: 1'b1, first: 1'b1, reset_faults: 1'b1, no_shutdown: 1'b0};
    if (a == CSSQ_LV_GND && b == CSSQ_LV_OPEN) r.reset_faults = 1'b0;
    else if (a == CSSQ_LV_GND && b == CSSQ_LV_VCC) r.first = 1'b0;
    else if (a == CSSQ_LV_OPEN && b == CSSQ_LV_GND)
      r = '{master: 1'b1, first: 1'b0, reset_faults: 1'b0, no_shutdown: 1'b0};
    else if (a == CSSQ_LV_OPEN && b == CSSQ_LV_OPEN) r.master = 1'b0;
    else if (a == CSSQ_LV_OPEN && b == CSSQ_LV_VCC)
      r = '{master: 1'b0, first: 1'b1, reset_faults: 1'b0, no_shutdown: 1'b0};
    else if (a == CSSQ_LV_VCC && b == CSSQ_LV_GND) r.no_shutdown = 1'b1;
    else if (a == CSSQ_LV_VCC && b == CSSQ_LV_OPEN)
      r = '{master: 1'b1, first: 1'b0, reset_faults: 1'b1, no_shutdown: 1'b1};
    else if (a == CSSQ_LV_VCC && b == CSSQ_LV_VCC)
      r = '{master: 1'b0, first: 1'b1, reset_faults: 1'b1, no_shutdown: 1'b1};
    return r;
  endfunction : cssq_decode
  // sequencer states
  typedef enum logic [2:0] {CSSQ_IDLE, CSSQ_WAIT_UP, CSSQ_UP_LOW, CSSQ_UP_HIGH, CSSQ_UP_DONE,
    CSSQ_DN_LOW, CSSQ_DN_HIGH, CSSQ_DN_DONE} cssq_state_t;
endpackage : cssq_pkg

/* File: logic/cssq_sync_if.sv */
// interface: synchronised pin levels from the input stage to the core
`timescale 1ns/1ps
interface cssq_sync_if;
  logic slot_clk_lvl; // resolved slot clock line level
  logic slot_clk_fall; // one-cycle pulse on falling edge
  logic slot_clk_rise; // one-cycle pulse on rising edge
  logic cmd_lvl; // sequence command level
  logic fin_lvl; // finish link level
  logic [3:0] up_ok; // supplies above up threshold
  logic [3:0] dn_ok; // supplies below down threshold
  modport src (output slot_clk_lvl, slot_clk_fall, slot_clk_rise, cmd_lvl, fin_lvl, up_ok,
    dn_ok);
  modport dst (input slot_clk_lvl, slot_clk_fall, slot_clk_rise, cmd_lvl, fin_lvl, up_ok,
    dn_ok);
endinterface : cssq_sync_if

/* File: logic/cssq_sync.sv */
// input stage: three-flop synchronisers with agreement check
`timescale 1ns/1ps
module cssq_sync
  import cssq_pkg::*;
#(
  parameter int W = 11
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  cssq_sync_if.src o
);
  logic [W-1:0] s1_q; // first stage, read only by s2
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q; // accepted level
  logic [W-1:0] agree;
  // three flops per input
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign agree = ~(s2_q ^ s3_q);
  // a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lvl_q <= '1;
    else
      lvl_q <= (s3_q & agree) | (lvl_q & ~agree);
  end
  assign o.slot_clk_lvl = lvl_q[0];
  assign o.slot_clk_fall = s3_q[0] & agree[0] ? 1'b0 : (lvl_q[0] & agree[0]);
  assign o.slot_clk_rise = (s3_q[0] & agree[0]) & ~lvl_q[0];
  assign o.cmd_lvl = lvl_q[1];
  assign o.fin_lvl = lvl_q[2];
  assign o.up_ok = lvl_q[6:3];
  assign o.dn_ok = lvl_q[10:7];
endmodule : cssq_sync

/* File: logic/cssq_slot_timer.sv */
// slot timer: counts the high period of the slot clock line
`timescale 1ns/1ps
module cssq_slot_timer
  import cssq_pkg::*;
#(
  parameter int CW = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start, // restart count
  input wire logic run, // count while high
  input wire logic [CW-1:0] period, // cycles per period
  output logic expired // level once period elapsed
);
  logic [CW-1:0] cnt_q;
  // saturating up counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (start)
      cnt_q <= '0;
    else if (run && !expired)
      cnt_q <= cnt_q + 1'b1;
  end
  assign expired = (cnt_q + 1'b1 >= period);
endmodule : cssq_slot_timer

/* File: logic/cssq_top.sv */
// top: cascade supply sequencer core with open-drain link pins
// Behaviour
// R1: master pulls slot clock low starting up
// R2: release slot clock when position supplies up
// R3: empty position releases after 25 us
// R4: high one slot period, at least 100 us
// R5: step to position 8, then done low
// R6: sequence down from 8 to 1
// R7: slave steps only on slot clock edges
// R8: role from two three-state pins
// R9: nine pin combinations decoded
// R10: last only with finish link pull-up
// R11: not-last drives finish link high when up
// R12: last drives finish link low when up
// R13: not-last forwards command low, defers down
// R14: last starts down on command low
// R15: not-first pulls previous link up after down
// R16: not-last downs when link pulled high
// R17: downstream releases link after upstream low
// R18: downstream waits for upstream completion
// R19: middle devices master, not-first, unloaded
// R20: wired lines, low dominates, read resolved
`timescale 1ns/1ps
module cssq_top
  import cssq_pkg::*;
#(
  parameter int SLOT_TIMER_CYC = SLOT_TIMER_DEF, // slot timer period in cycles
  parameter int CW = 24
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [1:0] ROLE_PIN_A, // cssq_level_t coded
  input wire logic [1:0] ROLE_PIN_B,
  input wire logic [3:0] POS_SUP0, // time position of supply 0, 0 = unused
  input wire logic [3:0] POS_SUP1,
  input wire logic [3:0] POS_SUP2,
  input wire logic [3:0] POS_SUP3,
  input wire logic [3:0] SUP_UP_OK, // supply above sequence-up threshold
  input wire logic [3:0] SUP_DN_OK, // supply below sequence-down threshold
  input wire logic SLOT_CLK_IN,
  output logic SLOT_CLK_OUT,
  output logic SLOT_CLK_OE_N,
  input wire logic CMD_IN,
  output logic CMD_OUT,
  output logic CMD_OE_N,
  input wire logic FIN_IN,
  output logic FIN_OUT,
  output logic FIN_OE_N,
  output logic [3:0] SUP_EN, // supply-gate enables
  output logic [3:0] CUR_POS // current time position
);
  localparam logic [CW-1:0] EMPTY_CYC = CW'(EMPTY_SLOT_CYC);
  localparam logic [CW-1:0] HIGH_CYC =
    CW'((SLOT_TIMER_CYC < MIN_HIGH_CYC) ? MIN_HIGH_CYC : SLOT_TIMER_CYC);
  cssq_sync_if sy ();
  cssq_state_t state_q;
  logic [3:0] pos_q; // current position
  logic [3:0] en_q; // enables
  logic slot_low_q; // pulling slot clock low
  logic fin_low_q; // pulling finish link low
  logic fin_high_q; // driving finish link high
  logic cmd_high_q; // driving command pin high
  logic last_q; // finish link pull-up sensed
  logic role_ok_q; // role captured
  logic [2:0] settle_q; // counts out the synchroniser reset value
  cssq_role_t role_q;
  logic [CW-1:0] empty_q; // empty position counter
  logic tmr_start;
  logic tmr_expired;
  logic [3:0] in_pos; // supplies of current position
  logic pos_up; // current position all up
  logic pos_dn; // current position all down
  logic step; // advance position
  logic [3:0] p [NUM_SUP];
  assign p[0] = POS_SUP0;
  assign p[1] = POS_SUP1;
  assign p[2] = POS_SUP2;
  assign p[3] = POS_SUP3;
  // synchronisers for the slot clock, command, finish link and supply status inputs
  cssq_sync #(.W(11)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .raw({SUP_DN_OK, SUP_UP_OK, FIN_IN, CMD_IN, SLOT_CLK_IN}),
    .o(sy.src)
  );
  // slot timer for the high half of each position
  cssq_slot_timer #(.CW(CW)) u_tmr (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .start(tmr_start),
    .run(!slot_low_q),
    .period(HIGH_CYC),
    .expired(tmr_expired)
  );
  // supplies assigned to the current position
  always_comb
  begin
    for (int i = 0; i < NUM_SUP; i++)
      in_pos[i] = (p[i] != 4'h0) && (p[i] == pos_q); // unused supplies never match
  end
  assign pos_up = &(~in_pos | sy.up_ok); // [R2]
  assign pos_dn = &(~in_pos | sy.dn_ok); // [R6]
  // master steps on its own slot timer; slaves follow the shared line
  assign step = role_q.master ? (tmr_expired && !slot_low_q) : sy.slot_clk_fall; // [R7]
  assign tmr_start = slot_low_q;
  // settle counter after reset release
  // the synchronisers reset to all ones, so command and link levels read high
  // for a few cycles; nothing may act on them before they carry the real pins
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      settle_q <= '0;
    else if (settle_q != ROLE_SETTLE_CYC)
      settle_q <= settle_q + 1'b1;
  end
  // role and last-status capture once the inputs have settled
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      role_ok_q <= 1'b0;
      role_q <= '0;
      last_q <= 1'b0;
    end
    else if (!role_ok_q && settle_q == ROLE_SETTLE_CYC)
    begin
      role_ok_q <= 1'b1;
      role_q <= cssq_decode(cssq_level_t'(ROLE_PIN_A), cssq_level_t'(ROLE_PIN_B)); // [R8] [R9]
      last_q <= sy.fin_lvl; // [R10] released link reads high only with pull-up
    end
  end
  // empty position counter
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      empty_q <= '0;
    else if (state_q != CSSQ_UP_LOW && state_q != CSSQ_DN_LOW)
      empty_q <= '0; // counts in a position for slaves too, which never pull the line
    else if (empty_q != EMPTY_CYC)
      empty_q <= empty_q + 1'b1;
  end
  // main sequencer
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= CSSQ_IDLE;
      pos_q <= POS_RESET;
      en_q <= '0;
      slot_low_q <= 1'b0;
      fin_low_q <= 1'b0; // link released so its pull-up can be sensed [R10]
      fin_high_q <= 1'b0;
      cmd_high_q <= 1'b0;
    end
    else if (role_ok_q)
    begin
      case (state_q)
        CSSQ_IDLE:
        begin
          cmd_high_q <= 1'b0;
          fin_high_q <= 1'b0;
          fin_low_q <= 1'b0; // released: downstream pulls up when done [R17]
          if (sy.cmd_lvl && role_q.master) // [R18] level only seen after upstream done
          begin
            state_q <= CSSQ_UP_LOW;
            pos_q <= FIRST_POS;
            slot_low_q <= 1'b1; // [R1]
          end
          else if (sy.cmd_lvl)
          begin
            // slave waits in front of position 1 for the master's first fall
            state_q <= CSSQ_UP_HIGH; // [R7]
            pos_q <= POS_RESET;
          end
        end
        CSSQ_UP_LOW:
        begin
          for (int i = 0; i < NUM_SUP; i++)
            if (in_pos[i]) en_q[i] <= 1'b1;
          if ((|in_pos && pos_up && en_q == (en_q | in_pos)) ||
              (!(|in_pos) && empty_q == EMPTY_CYC)) // [R2] [R3]
          begin
            slot_low_q <= 1'b0;
            state_q <= CSSQ_UP_HIGH;
          end
        end
        CSSQ_UP_HIGH:
        begin
          if (sy.slot_clk_lvl && step) // [R4] [R20] read resolved level
          begin
            if (pos_q == LAST_POS)
            begin
              state_q <= CSSQ_UP_DONE; // [R5]
              if (last_q) fin_low_q <= 1'b1; // [R12]
              else fin_high_q <= 1'b1; // [R11]
            end
            else
            begin
              pos_q <= pos_q + 1'b1;
              slot_low_q <= role_q.master;
              state_q <= CSSQ_UP_LOW;
            end
          end
        end
        CSSQ_UP_DONE:
        begin
          if (!sy.cmd_lvl)
          begin
            if (last_q)
            begin
              state_q <= CSSQ_DN_LOW; // [R14]
              pos_q <= LAST_POS;
              slot_low_q <= role_q.master;
            end
            else
            begin
              fin_high_q <= 1'b0; // [R13] forward low, wait for pull-up
              fin_low_q <= 1'b1;
              state_q <= CSSQ_WAIT_UP;
            end
          end
        end
        CSSQ_WAIT_UP:
        begin
          if (fin_low_q)
            fin_low_q <= 1'b0; // release to sense downstream pull-up
          else if (sy.fin_lvl) // [R16]
          begin
            state_q <= CSSQ_DN_LOW;
            pos_q <= LAST_POS;
            slot_low_q <= role_q.master;
          end
        end
        CSSQ_DN_LOW:
        begin
          for (int i = 0; i < NUM_SUP; i++)
            if (in_pos[i]) en_q[i] <= 1'b0; // [R6]
          // an empty position still lasts the full empty window going down
          if ((|in_pos && pos_dn && (en_q & in_pos) == 4'h0) ||
              (!(|in_pos) && empty_q == EMPTY_CYC)) // [R3] [R6]
          begin
            slot_low_q <= 1'b0;
            state_q <= CSSQ_DN_HIGH;
          end
        end
        CSSQ_DN_HIGH:
        begin
          if (sy.slot_clk_lvl && step)
          begin
            if (pos_q == FIRST_POS)
            begin
              state_q <= CSSQ_DN_DONE;
              fin_low_q <= 1'b1; // [R15] [R16] hold link low
              cmd_high_q <= !role_q.first; // [R15]
            end
            else
            begin
              pos_q <= pos_q - 1'b1;
              slot_low_q <= role_q.master;
              state_q <= CSSQ_DN_LOW;
            end
          end
        end
        CSSQ_DN_DONE:
        begin
          // wait for upstream to pull command line low again
          if (!role_q.first && !sy.cmd_lvl)
          begin
            cmd_high_q <= 1'b0;
            state_q <= CSSQ_IDLE; // [R17]
          end
          else if (role_q.first)
            state_q <= CSSQ_IDLE;
        end
        default: state_q <= CSSQ_IDLE;
      endcase
    end
  end
  // open-drain style pins, enable low while driving [R20]
  assign SLOT_CLK_OUT = 1'b0;
  assign SLOT_CLK_OE_N = !slot_low_q;
  assign FIN_OUT = fin_high_q;
  assign FIN_OE_N = !(fin_low_q || fin_high_q);
  assign CMD_OUT = 1'b1;
  assign CMD_OE_N = !cmd_high_q;
  assign SUP_EN = en_q;
  assign CUR_POS = pos_q;
  // slot clock held low only while filling a position
  slot_low_state_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !SLOT_CLK_OE_N |-> (state_q == CSSQ_UP_LOW || state_q == CSSQ_DN_LOW)) // [R1]
    else $error("slot clock low outside position");
  // empty position releases within the window
  empty_rel_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (state_q == CSSQ_UP_LOW && empty_q == EMPTY_CYC && !(|in_pos)) |=> !slot_low_q) // [R3]
    else $error("empty position not released");
  // position never exceeds the last one
  pos_range_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    pos_q <= LAST_POS) // [R5]
    else $error("position out of range");
  // a slave never pulls the shared slot clock line
  slave_quiet_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (role_ok_q && !role_q.master) |-> SLOT_CLK_OE_N) // [R7]
    else $error("slave pulls slot clock");
  // the last device holds the finish link low once sequence-up is done
  last_fin_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (state_q == CSSQ_UP_DONE && last_q) |-> (!FIN_OE_N && !FIN_OUT)) // [R12]
    else $error("finish link not low after sequence-up");
  // a master keeps the line high until its slot timer runs out
  high_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (state_q == CSSQ_UP_HIGH && role_q.master && !tmr_expired) |=>
    (state_q == CSSQ_UP_HIGH)) // [R4]
    else $error("position advanced before slot timer");
  // nothing stays enabled while idle
  idle_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (state_q == CSSQ_IDLE) |-> (SUP_EN == 4'h0)) // [R6]
    else $error("supply enabled while idle");
endmodule : cssq_top

/* File: test/cssq_far_model.sv */
// far side model: wired link lines with pull-ups and four ramping supplies
`timescale 1ns/1ps
module cssq_far_model
  import cssq_pkg::*;
#(
  parameter int RAMP = 40 // supply settle time in cycles, arbitrary
) (
  input wire logic clk,
  input wire logic slot_oe_n, // device pulls slot line when low
  input wire logic slot_out,
  input wire logic ext_slot_low, // another master pulling the slot line
  input wire logic fin_oe_n, // device drives finish link when low
  input wire logic fin_out,
  input wire logic [3:0] sup_en, // supply-gate enables from the device
  output logic slot_line, // resolved slot clock line
  output logic fin_line, // resolved finish link
  output logic [3:0] up_ok, // supplies above up threshold
  output logic [3:0] dn_ok // supplies below down threshold
);
  int ramp [4]; // per-supply settle progress
  // wired slot line: any low wins, pull-up otherwise, nothing else loads it
  assign slot_line = ~ext_slot_low & (slot_oe_n | slot_out);
  // finish link pull-up present, so the device sees itself as last
  assign fin_line = fin_oe_n ? 1'b1 : fin_out;
  // supplies take a while to cross either threshold, never instantly
  always_ff @(posedge clk)
  begin
    foreach (ramp[i])
    begin
      if (sup_en[i] && ramp[i] < RAMP) ramp[i] <= ramp[i] + 1;
      else if (!sup_en[i] && ramp[i] > 0) ramp[i] <= ramp[i] - 1;
    end
  end
  // threshold flags from settle progress
  always_comb
  begin
    foreach (ramp[i])
    begin
      up_ok[i] = (ramp[i] == RAMP);
      dn_ok[i] = (ramp[i] == 0);
    end
  end
endmodule : cssq_far_model

/* File: test/tb.sv */
// testbench: sequence-up, sequence-down and slave stepping of the sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
  import cssq_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] role_a = CSSQ_LV_GND;
  logic [1:0] role_b = CSSQ_LV_GND;
  logic cmd = 1'b0; // system controller command
  logic ext_low = 1'b0; // stands in for an outside master
  logic [3:0] pos [4] = '{4'h1, 4'h3, 4'h3, 4'h8}; // positions of supplies 0..3
  logic slot_line, fin_line, slot_out, slot_oe_n, fin_out, fin_oe_n;
  logic [3:0] up_ok, dn_ok, sup_en, cur_pos;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // 40 MHz clock
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  cssq_top #(.SLOT_TIMER_CYC(SLOT_TIMER_DEF)) i_dut (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .ROLE_PIN_A(role_a), .ROLE_PIN_B(role_b),
    .POS_SUP0(pos[0]), .POS_SUP1(pos[1]), .POS_SUP2(pos[2]), .POS_SUP3(pos[3]),
    .SUP_UP_OK(up_ok), .SUP_DN_OK(dn_ok), .SLOT_CLK_IN(slot_line),
    .SLOT_CLK_OUT(slot_out), .SLOT_CLK_OE_N(slot_oe_n), .CMD_IN(cmd), .CMD_OUT(),
    .CMD_OE_N(), .FIN_IN(fin_line), .FIN_OUT(fin_out), .FIN_OE_N(fin_oe_n),
    .SUP_EN(sup_en), .CUR_POS(cur_pos)
  );
  cssq_far_model i_far (
    .clk(sys_clk), .slot_oe_n(slot_oe_n), .slot_out(slot_out), .ext_slot_low(ext_low),
    .fin_oe_n(fin_oe_n), .fin_out(fin_out), .sup_en(sup_en), .slot_line(slot_line),
    .fin_line(fin_line), .up_ok(up_ok), .dn_ok(dn_ok)
  );
  // verdict and end of run
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // hang guard, well above the expected run of about 79k cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      n_errors++;
      $display("mismatch at %0t run limit reached", $time);
      conclude();
    end
  end
  // reset with the given role pin levels
  task automatic do_reset(input logic [1:0] a, input logic [1:0] b);
    @(negedge sys_clk);
    reset_n = 1'b0;
    role_a = a;
    role_b = b;
    cmd = 1'b0;
    ext_low = 1'b0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask : do_reset
  // count cycles until the slot line reaches a level, bounded
  task automatic wait_slot(input logic lvl, input int max, output int n);
    n = 0;
    while (slot_line !== lvl && n < max)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_slot
  // enables expected once position p is reached
  function automatic logic [3:0] up_mask(input int p);
    logic [3:0] m;
    m = 4'h0;
    foreach (pos[i]) m[i] = (pos[i] != 4'h0) && (int'(pos[i]) <= p);
    return m;
  endfunction : up_mask
  // master walks all eight positions, empty ones time out
  task automatic sc_seq_up();
    int n;
    logic [3:0] exp;
    @(negedge sys_clk);
    cmd = 1'b1;
    wait_slot(1'b0, 20, n);
    `CHK(n <= 8, 1'b1)
    for (int p = 1; p <= 8; p++)
    begin
      if (p > 1)
      begin
        wait_slot(1'b0, 5000, n);
        `CHK(n >= MIN_HIGH_CYC && n <= SLOT_TIMER_DEF + 8, 1'b1)
      end
      repeat (2) @(negedge sys_clk);
      exp = up_mask(p);
      `CHK(cur_pos, 4'(p))
      `CHK(sup_en, exp)
      wait_slot(1'b1, 2000, n);
      n += 2;
      if (exp == up_mask(p - 1))
        `CHK(n >= EMPTY_SLOT_CYC && n <= EMPTY_SLOT_CYC + 8, 1'b1)
      else
        `CHK(up_ok & exp, exp)
    end
    n = 0;
    while (fin_oe_n !== 1'b0 && n < 6000)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(fin_oe_n, 1'b0)
    `CHK(fin_line, 1'b0)
  endtask : sc_seq_up
  // last device steps down from position 8 to 1, then releases the link
  task automatic sc_seq_down();
    int n;
    @(negedge sys_clk);
    cmd = 1'b0;
    n = 0;
    while (sup_en[3] !== 1'b0 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(sup_en, 4'h7)
    n = 0;
    while (sup_en !== 4'h0 && n < 60000)
    begin
      @(negedge sys_clk);
      n++;
      `CHK(sup_en[0] == 1'b0 && sup_en[2:1] != 2'h0, 1'b0)
    end
    `CHK(sup_en, 4'h0)
    n = 0;
    while (fin_line !== 1'b1 && n < 6000)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(fin_line, 1'b1)
    `CHK(dn_ok, 4'hf)
  endtask : sc_seq_down
  // slave never drives the line and steps only on the master's edges
  task automatic sc_slave();
    int n;
    do_reset(CSSQ_LV_OPEN, CSSQ_LV_OPEN);
    cmd = 1'b1;
    repeat (100) @(negedge sys_clk);
    `CHK(slot_oe_n, 1'b1)
    ext_low = 1'b1;
    n = 0;
    while (cur_pos !== 4'h1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(cur_pos, 4'h1)
    repeat (2) @(negedge sys_clk);
    `CHK(sup_en, 4'h1)
    ext_low = 1'b0;
    repeat (SLOT_TIMER_DEF + 200) @(negedge sys_clk);
    `CHK(cur_pos, 4'h1)
    `CHK(slot_oe_n, 1'b1)
  endtask : sc_slave
  // main sequence
  initial
  begin
    do_reset(CSSQ_LV_GND, CSSQ_LV_GND);
    sc_seq_up();
    sc_seq_down();
    sc_slave();
    conclude();
  end
endmodule : tb
